// ==== hw/fcl_map.svh ====
// register offsets, field positions, reset values and command codes of the launch sequencer
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH
// register byte offsets on the apb bus
`define FCL_OFF_CLKDIV 8'h00
`define FCL_OFF_INDEX 8'h04
`define FCL_OFF_STATUS 8'h08
`define FCL_OFF_PROT 8'h0c
`define FCL_OFF_DPROT 8'h10
`define FCL_OFF_PARAM 8'h14
// field positions
`define FCL_CLKDIV_LOADED 7
`define FCL_ST_COMMAND_COMPLETE_FLAG 7
`define FCL_ST_ACCESS_ERROR_FLAG 5
`define FCL_ST_PROTECTION_VIOLATION_FLAG 4
`define FCL_PROT_OPEN 7
`define FCL_PROT_HDIS 5
`define FCL_PROT_LDIS 2
`define FCL_DPROT_OPEN 7
`define FCL_BLK_PFLASH 6
// parameter words
`define FCL_NUM_WORDS 6
`define FCL_INDEX_MAX 3'h5
// reset values
`define FCL_RST_COMMAND_COMPLETE_FLAG 1'b1
`define FCL_RST_PROT 8'h00
`define FCL_RST_DPROT 8'h00
// command codes
`define FCL_CMD_EV_ALL 8'h01
`define FCL_CMD_EV_BLK 8'h02
`define FCL_CMD_EV_PSEC 8'h03
`define FCL_CMD_RD_ONCE 8'h04
`define FCL_CMD_PG_P 8'h06
`define FCL_CMD_PG_ONCE 8'h07
`define FCL_CMD_ER_ALL 8'h08
`define FCL_CMD_ER_BLK 8'h09
`define FCL_CMD_ER_PSEC 8'h0a
`define FCL_CMD_UNSEC 8'h0b
`define FCL_CMD_KEY 8'h0c
`define FCL_CMD_UMARGIN 8'h0d
`define FCL_CMD_FMARGIN 8'h0e
`define FCL_CMD_EV_DSEC 8'h10
`define FCL_CMD_PG_D 8'h11
`define FCL_CMD_ER_DSEC 8'h12
`endif

// ==== hw/fcl_pkg.sv ====
// types of the flash command launch sequencer
`default_nettype none
package fcl_pkg;
  typedef enum logic [1:0] {
    FCL_NORMAL_SINGLE,
    FCL_NORMAL_EXPANDED,
    FCL_SPECIAL_SINGLE,
    FCL_SPECIAL
  } fcl_mode_type;

  typedef enum logic {FCL_IDLE, FCL_BUSY} fcl_phase_type;

  typedef logic [5:0][15:0] fcl_words_type;

  typedef struct packed {
    logic launch;
    fcl_words_type words;
  } fcl_cmd_type;

  typedef struct packed {
    fcl_phase_type phase;
    logic [6:0] fdiv;
    logic fdiv_loaded;
    logic [2:0] index;
    fcl_words_type words;
    logic command_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic [7:0] prot;
    logic [7:0] dprot;
    logic once_used;
    logic launch;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fcl_state_type;
endpackage
`default_nettype wire

// ==== hw/fcl_top.sv ====
// flash command launch sequencer with apb register slave
//
// Register access over APB and the placing of the registers were left to the implementer.
`include "fcl_map.svh"
`default_nettype none
module fcl_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic secured,
  input wire fcl_pkg::fcl_mode_type mode,
  output fcl_pkg::fcl_cmd_type eng_cmd,
  input wire logic eng_done,
  input wire fcl_pkg::fcl_words_type eng_result,
  output logic cmd_complete
);
  // ==========================================================
  // command decoding
  function automatic logic code_defined(input logic [7:0] c);
    case (c)
      `FCL_CMD_EV_ALL, `FCL_CMD_EV_BLK, `FCL_CMD_EV_PSEC, `FCL_CMD_RD_ONCE,
      `FCL_CMD_PG_P, `FCL_CMD_PG_ONCE, `FCL_CMD_ER_ALL, `FCL_CMD_ER_BLK,
      `FCL_CMD_ER_PSEC, `FCL_CMD_UNSEC, `FCL_CMD_KEY, `FCL_CMD_UMARGIN,
      `FCL_CMD_FMARGIN, `FCL_CMD_EV_DSEC, `FCL_CMD_PG_D, `FCL_CMD_ER_DSEC: begin
        code_defined = 1'b1;
      end
      default: begin
        code_defined = 1'b0;
      end
    endcase
  endfunction

  function automatic logic code_allowed(input logic [7:0] c, input logic sec,
                                        input fcl_pkg::fcl_mode_type m);
    logic special;
    logic nsingle;
    special = (m == fcl_pkg::FCL_SPECIAL_SINGLE) || (m == fcl_pkg::FCL_SPECIAL);
    nsingle = (m == fcl_pkg::FCL_NORMAL_SINGLE);
    case (c)
      `FCL_CMD_EV_ALL, `FCL_CMD_EV_BLK: begin
        code_allowed = 1'b1;
      end
      `FCL_CMD_ER_ALL, `FCL_CMD_UNSEC: begin
        code_allowed = special;
      end
      `FCL_CMD_FMARGIN: begin
        code_allowed = special && !sec;
      end
      `FCL_CMD_KEY: begin
        code_allowed = nsingle;
      end
      default: begin
        code_allowed = !sec || nsingle;
      end
    endcase
  endfunction

  function automatic logic code_modifies(input logic [7:0] c);
    case (c)
      `FCL_CMD_PG_P, `FCL_CMD_PG_ONCE, `FCL_CMD_ER_ALL, `FCL_CMD_ER_BLK,
      `FCL_CMD_ER_PSEC, `FCL_CMD_UNSEC, `FCL_CMD_PG_D, `FCL_CMD_ER_DSEC: begin
        code_modifies = 1'b1;
      end
      default: begin
        code_modifies = 1'b0;
      end
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      `FCL_OFF_CLKDIV, `FCL_OFF_INDEX, `FCL_OFF_STATUS, `FCL_OFF_PROT, `FCL_OFF_DPROT,
      `FCL_OFF_PARAM: begin
        addr_mapped = 1'b1;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  endfunction

  // ==========================================================
  // state and decode
  fcl_pkg::fcl_state_type q;
  fcl_pkg::fcl_state_type d;
  logic setup;
  logic wr;
  logic launch_try;
  logic [7:0] code;
  logic pprot_open;
  logic all_open;
  logic blk_ok;

  assign setup = psel && !penable;
  assign wr = psel && penable && q.pready && pwrite;
  assign code = q.words[0][15:8];
  // launch only counts when the previous sequence is over and errors are clear
  assign launch_try = wr && (paddr == `FCL_OFF_STATUS) && pwdata[`FCL_ST_COMMAND_COMPLETE_FLAG] && q.command_complete_flag
    && !q.access_error_flag && !q.protection_violation_flag;
  assign pprot_open = q.prot[`FCL_PROT_LDIS] && q.prot[`FCL_PROT_HDIS]
    && q.prot[`FCL_PROT_OPEN];
  assign all_open = pprot_open && q.dprot[`FCL_DPROT_OPEN];
  // block select: bit 6 of parameter word 0 picks program flash, else data flash
  assign blk_ok = q.words[0][`FCL_BLK_PFLASH] ? pprot_open : q.dprot[`FCL_DPROT_OPEN];

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.launch = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (setup) begin
      d.pready = 1'b1;
      d.pslverr = !addr_mapped(paddr);
      case (paddr)
        `FCL_OFF_CLKDIV: begin
          d.prdata = {24'h000000, q.fdiv_loaded, q.fdiv};
        end
        `FCL_OFF_INDEX: begin
          d.prdata = {29'h00000000, q.index};
        end
        `FCL_OFF_STATUS: begin
          d.prdata = {24'h000000, q.command_complete_flag, 1'b0, q.access_error_flag, q.protection_violation_flag, 4'h0};
        end
        `FCL_OFF_PROT: begin
          d.prdata = {24'h000000, q.prot};
        end
        `FCL_OFF_DPROT: begin
          d.prdata = {24'h000000, q.dprot};
        end
        `FCL_OFF_PARAM: begin
          d.prdata = (q.index <= `FCL_INDEX_MAX) ? {16'h0000, q.words[q.index]} : 32'h00000000;
        end
        default: begin
          d.prdata = 32'h00000000;
        end
      endcase
    end
    if (wr && q.command_complete_flag) begin
      // configuration is frozen while a command runs
      case (paddr)
        `FCL_OFF_CLKDIV: begin
          d.fdiv = pwdata[6:0];
          d.fdiv_loaded = 1'b1;
        end
        `FCL_OFF_INDEX: begin
          d.index = pwdata[2:0];
        end
        `FCL_OFF_PROT: begin
          d.prot = pwdata[7:0];
        end
        `FCL_OFF_DPROT: begin
          d.dprot = pwdata[7:0];
        end
        `FCL_OFF_PARAM: begin
          if (q.index <= `FCL_INDEX_MAX) begin
            d.words[q.index] = pwdata[15:0];
          end
        end
        `FCL_OFF_STATUS: begin
          if (pwdata[`FCL_ST_ACCESS_ERROR_FLAG]) begin
            d.access_error_flag = 1'b0;
          end
          if (pwdata[`FCL_ST_PROTECTION_VIOLATION_FLAG]) begin
            d.protection_violation_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    case (q.phase)
      fcl_pkg::FCL_IDLE: begin
        if (launch_try) begin
          if (!code_defined(code) || !code_allowed(code, secured, mode)) begin
            d.access_error_flag = 1'b1;
          end else if (code_modifies(code) && !q.fdiv_loaded) begin
            d.access_error_flag = 1'b1;
          end else if (code == `FCL_CMD_PG_ONCE && q.once_used) begin
            d.access_error_flag = 1'b1;
          end else if ((code == `FCL_CMD_ER_ALL && !all_open)
                       || (code == `FCL_CMD_ER_BLK && !blk_ok)) begin
            d.protection_violation_flag = 1'b1;
          end else begin
            d.command_complete_flag = 1'b0;
            d.launch = 1'b1;
            d.phase = fcl_pkg::FCL_BUSY;
          end
        end
      end
      fcl_pkg::FCL_BUSY: begin
        if (eng_done) begin
          d.command_complete_flag = 1'b1;
          d.words = eng_result;
          d.phase = fcl_pkg::FCL_IDLE;
          if (code == `FCL_CMD_PG_ONCE) begin
            d.once_used = 1'b1;
          end
        end
      end
      default: begin
        d.phase = fcl_pkg::FCL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.command_complete_flag <= `FCL_RST_COMMAND_COMPLETE_FLAG;
      q.prot <= `FCL_RST_PROT;
      q.dprot <= `FCL_RST_DPROT;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign eng_cmd = '{launch: q.launch, words: q.words};
  assign cmd_complete = q.command_complete_flag;

  // ==========================================================
  // assertions
  property p_param_frozen;
    @(posedge clk) disable iff (rst)
    (wr && paddr == `FCL_OFF_PARAM && !q.command_complete_flag && !eng_done) |=> $stable(q.words);
  endproperty
  a_param_frozen: assert property (p_param_frozen) else $error("param written while busy");

  property p_param_index;
    @(posedge clk) disable iff (rst)
    (setup && paddr == `FCL_OFF_PARAM && q.index == 3'h2)
      |=> (prdata[15:0] == $past(q.words[2]));
  endproperty
  a_param_index: assert property (p_param_index) else $error("indexed read wrong word");

  property p_launch;
    @(posedge clk) disable iff (rst)
    eng_cmd.launch |-> (!cmd_complete && $past(launch_try));
  endproperty
  a_launch: assert property (p_launch) else $error("launch without valid request");

  property p_busy_low;
    @(posedge clk) disable iff (rst)
    (eng_cmd.launch && !eng_done) |=> !cmd_complete;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("complete flag rose early");

  property p_done;
    @(posedge clk) disable iff (rst)
    (q.phase == fcl_pkg::FCL_BUSY && eng_done) |=> (cmd_complete && q.words == $past(eng_result));
  endproperty
  a_done: assert property (p_done) else $error("completion not reported");

  property p_undefined;
    @(posedge clk) disable iff (rst)
    (launch_try && !code_defined(code)) |=> (q.access_error_flag && cmd_complete && !eng_cmd.launch);
  endproperty
  a_undefined: assert property (p_undefined) else $error("undefined code not refused");

  property p_no_div;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_PG_P && !q.fdiv_loaded) |=> (q.access_error_flag && !eng_cmd.launch);
  endproperty
  a_no_div: assert property (p_no_div) else $error("program ran without divider");

  property p_erase_all_prot;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_ER_ALL && !all_open) |=> !eng_cmd.launch;
  endproperty
  a_erase_all_prot: assert property (p_erase_all_prot) else $error("erase all while protected");

  property p_fmargin_sec;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_FMARGIN && secured) |=> (q.access_error_flag && cmd_complete);
  endproperty
  a_fmargin_sec: assert property (p_fmargin_sec) else $error("field margin when secured");

  property p_key_mode;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_KEY && mode != fcl_pkg::FCL_NORMAL_SINGLE) |=> q.access_error_flag;
  endproperty
  a_key_mode: assert property (p_key_mode) else $error("key check outside normal single");

  property p_once;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_PG_ONCE && q.once_used) |=> (!eng_cmd.launch && q.access_error_flag);
  endproperty
  a_once: assert property (p_once) else $error("one-time field programmed twice");

  property p_busy_hold;
    @(posedge clk) disable iff (rst)
    (q.phase == fcl_pkg::FCL_BUSY && !eng_done) |=> !cmd_complete;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("complete flag set while busy");

  property p_launch_pulse;
    @(posedge clk) disable iff (rst)
    eng_cmd.launch |=> !eng_cmd.launch;
  endproperty
  a_launch_pulse: assert property (p_launch_pulse) else $error("launch longer than one cycle");

  property p_err_no_launch;
    @(posedge clk) disable iff (rst)
    (wr && paddr == `FCL_OFF_STATUS && pwdata[`FCL_ST_COMMAND_COMPLETE_FLAG] && (q.access_error_flag || q.protection_violation_flag))
      |=> !eng_cmd.launch;
  endproperty
  a_err_no_launch: assert property (p_err_no_launch) else $error("launch with error set");

  property p_busy_no_launch;
    @(posedge clk) disable iff (rst)
    (wr && paddr == `FCL_OFF_STATUS && !q.command_complete_flag) |=> !eng_cmd.launch;
  endproperty
  a_busy_no_launch: assert property (p_busy_no_launch) else $error("launch while busy");

  property p_secured_restrict;
    @(posedge clk) disable iff (rst)
    (launch_try && secured && mode == fcl_pkg::FCL_NORMAL_EXPANDED && code != `FCL_CMD_EV_ALL
      && code != `FCL_CMD_EV_BLK) |=> (q.access_error_flag && cmd_complete && !eng_cmd.launch);
  endproperty
  a_secured_restrict: assert property (p_secured_restrict) else $error("secured code ran");

  property p_unsec_special;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_UNSEC && (mode == fcl_pkg::FCL_NORMAL_SINGLE
      || mode == fcl_pkg::FCL_NORMAL_EXPANDED)) |=> (q.access_error_flag && !eng_cmd.launch);
  endproperty
  a_unsec_special: assert property (p_unsec_special) else $error("unsecure in normal mode");

  property p_dflash_open;
    @(posedge clk) disable iff (rst)
    (launch_try && !secured && code == `FCL_CMD_EV_DSEC) |=> (eng_cmd.launch && !cmd_complete);
  endproperty
  a_dflash_open: assert property (p_dflash_open) else $error("data check refused");

  property p_blk_prot;
    @(posedge clk) disable iff (rst)
    (launch_try && code == `FCL_CMD_ER_BLK && q.words[0][`FCL_BLK_PFLASH] && !pprot_open
      && code_allowed(code, secured, mode) && q.fdiv_loaded) |=> (q.protection_violation_flag && !eng_cmd.launch);
  endproperty
  a_blk_prot: assert property (p_blk_prot) else $error("protected block erased");

  property p_user_margin;
    @(posedge clk) disable iff (rst)
    (launch_try && !secured && code == `FCL_CMD_UMARGIN) |=> eng_cmd.launch;
  endproperty
  a_user_margin: assert property (p_user_margin) else $error("user margin refused");
endmodule
`default_nettype wire

// ==== testbench/fcl_engine_model.sv ====
// flash engine stand-in that answers each launch after a chosen delay
`default_nettype none
module fcl_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire fcl_pkg::fcl_cmd_type cmd,
  input wire logic [3:0] lat,
  output logic done,
  output fcl_pkg::fcl_words_type result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  logic [3:0] cnt;
  // results are the inverted parameter words
  assign result = ~cmd.words;
  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cmd.launch) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
        if (cnt <= 4'h1) begin
          done <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench of the flash command launch sequencer
`include "fcl_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic secured = 1'b0, pready, pslverr, eng_done, cmd_complete, err, once_used = 1'b0;
  logic div_ok = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, v, seed;
  logic [3:0] lat = 4'h1;
  fcl_pkg::fcl_mode_type mode = fcl_pkg::FCL_NORMAL_SINGLE;
  fcl_pkg::fcl_cmd_type eng_cmd;
  fcl_pkg::fcl_words_type eng_result, cap, wv;
  int bad_count = 0, tests_run = 0, cyc = 0, launches = 0, n0 = 0;
  logic [7:0] codes [21] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
    8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h00, 8'h05, 8'h0f, 8'h13, 8'hff};

  fcl_top fcl_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .secured(secured), .mode(mode), .eng_cmd(eng_cmd),
    .eng_done(eng_done), .eng_result(eng_result), .cmd_complete(cmd_complete));
  fcl_engine_model fcl_engine_model_inst (.clk(clk), .rst(rst), .cmd(eng_cmd), .lat(lat),
    .done(eng_done), .result(eng_result));

  initial forever #25 clk = ~clk;

  // ==========
  // launch monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (eng_cmd.launch === 1'b1) begin
      launches <= launches + 1;
      cap <= eng_cmd.words;
    end
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  // ==========
  // tasks
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_done;
    repeat (2) @(posedge clk);
    while (cmd_complete !== 1'b1) @(posedge clk);
  endtask

  function automatic logic ok_code(logic [7:0] c, logic [1:0] m, logic s);
    logic a;
    case (c)
      8'h01, 8'h02: a = 1'b1;
      8'h08, 8'h0b: a = m[1];
      8'h0e: a = m[1] & ~s;
      8'h0c: a = (m == 2'h0);
      8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12:
        a = ~s | (m == 2'h0);
      default: a = 1'b0;
    endcase
    if (c inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h11, 8'h12} && !div_ok) a = 1'b0;
    return a & ~(c == 8'h07 && once_used);
  endfunction

  task run(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] st);
    int n;
    apb(1'b1, `FCL_OFF_INDEX, 32'h0);
    apb(1'b1, `FCL_OFF_PARAM, {16'h0, c, lo});
    n = launches;
    lat <= 4'($urandom_range(1, 8));
    apb(1'b1, `FCL_OFF_STATUS, 32'h80);
    wait_done;
    apb(1'b0, `FCL_OFF_STATUS, 32'h0);
    chk("status", v, {24'h0, st});
    chk("complete pin", {31'h0, cmd_complete}, 32'h1);
    chk("launch count", launches - n, {31'h0, st == 8'h80});
    if (v[5] | v[4]) apb(1'b1, `FCL_OFF_STATUS, {24'h0, v[7:0] & 8'h30});
    if (c == 8'h07 && st == 8'h80) once_used = 1'b1;
  endtask

  // ==========
  // main sequence
  initial begin
    seed = $urandom(12277);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `FCL_OFF_STATUS, 32'h0);
    chk("status after reset", v, 32'h80);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", v, 32'h0);
    apb(1'b1, `FCL_OFF_PARAM, 32'h0500);
    apb(1'b1, `FCL_OFF_STATUS, 32'h80);
    n0 = launches;
    apb(1'b1, `FCL_OFF_PARAM, 32'h0100);
    apb(1'b1, `FCL_OFF_STATUS, 32'h80);
    apb(1'b0, `FCL_OFF_STATUS, 32'h0);
    chk("launch with error set", v, 32'ha0);
    chk("no launch with error", launches - n0, 32'h0);
    apb(1'b1, `FCL_OFF_STATUS, 32'h20);
    run(8'h06, 8'h00, 8'ha0);
    run(8'h01, 8'h00, 8'h80);
    apb(1'b1, `FCL_OFF_CLKDIV, 32'h13);
    div_ok = 1'b1;
    apb(1'b0, `FCL_OFF_CLKDIV, 32'h0);
    chk("divider", v, 32'h93);
    mode <= fcl_pkg::FCL_SPECIAL;
    run(8'h08, 8'h00, 8'h90);
    run(8'h09, 8'h40, 8'h90);
    apb(1'b1, `FCL_OFF_PROT, 32'ha4);
    apb(1'b1, `FCL_OFF_DPROT, 32'h80);
    mode <= fcl_pkg::FCL_NORMAL_SINGLE;
    for (int i = 0; i < 6; i++) begin
      wv[i] = (i == 0) ? {8'h0d, 8'($urandom)} : 16'($urandom);
      apb(1'b1, `FCL_OFF_INDEX, 32'(i));
      apb(1'b1, `FCL_OFF_PARAM, {16'h0, wv[i]});
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FCL_OFF_INDEX, 32'(i));
      apb(1'b0, `FCL_OFF_PARAM, 32'h0);
      chk("param word", v, {16'h0, wv[i]});
    end
    lat <= 4'hf;
    apb(1'b1, `FCL_OFF_STATUS, 32'h80);
    apb(1'b0, `FCL_OFF_STATUS, 32'h0);
    chk("busy status", v, 32'h0);
    apb(1'b1, `FCL_OFF_PARAM, 32'hffff);
    apb(1'b1, `FCL_OFF_STATUS, 32'hb0);
    @(posedge clk);
    chk("relaunch while busy", {31'h0, eng_cmd.launch}, 32'h0);
    chk("complete pin while busy", {31'h0, cmd_complete}, 32'h0);
    chk("handed words", {31'h0, cap === wv}, 32'h1);
    chk("words while busy", {31'h0, eng_cmd.words === wv}, 32'h1);
    wait_done;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FCL_OFF_INDEX, 32'(i));
      apb(1'b0, `FCL_OFF_PARAM, 32'h0);
      chk("result word", v, {16'h0, ~wv[i]});
    end
    foreach (codes[k]) begin
      for (int m = 0; m < 4; m++) begin
        for (int s = 0; s < 2; s++) begin
          mode <= fcl_pkg::fcl_mode_type'(m[1:0]);
          secured <= s[0];
          run(codes[k], 8'($urandom), ok_code(codes[k], m[1:0], s[0]) ? 8'h80 : 8'ha0);
        end
      end
    end
    end_sim;
  end
endmodule
`default_nettype wire
